/* src/vc_cap_map.svh */
`ifndef VC_CAP_MAP_SVH
`define VC_CAP_MAP_SVH

// Register indices; byte address is four times the index
`define VC_STATUS_IDX 12'h20e
`define VC_CAP_IDX 12'h210
`define VC_STATUS_ADDR (`VC_STATUS_IDX << 2)
`define VC_CAP_ADDR (`VC_CAP_IDX << 2)

// Field positions of the capability word
`define VC_ARB_CAP_LSB 0
`define VC_ADV_PKT_SW_BIT 14
`define VC_REJECT_SNOOP_BIT 15
`define VC_MAX_TS_LSB 16
`define VC_TBL_OFF_LSB 24

// Field positions of the status word
`define VC_TBL_COHERENT_BIT 0
`define VC_STATUS_WIDTH 16

// Field values
`define VC_TBL_COHERENT_VAL 1'h0
`define VC_ARB_CAP_UP 8'h03
`define VC_ARB_CAP_DN 8'h01
`define VC_ADV_PKT_SW_VAL 1'h0
`define VC_REJECT_SNOOP_VAL 1'h0
`define VC_MAX_TS_VAL 7'h00
`define VC_TBL_OFF_UP 8'h02
`define VC_TBL_OFF_DN 8'h00

// Bus responses
`define AXIL_RESP_OKAY 2'h0
`define AXIL_RESP_SLVERR 2'h2

`endif

/* src/vc_cap_pkg.sv */
`include "vc_cap_map.svh"

package vc_cap_pkg;

	typedef struct packed
	{
		logic [11:0] addr;
		logic [2:0] prot;
	} axilAddr_t;

	typedef struct packed
	{
		logic [31:0] data;
		logic [3:0] strb;
	} axilWdata_t;

	typedef struct packed
	{
		logic [31:0] data;
		logic [1:0] resp;
	} axilRdata_t;

	typedef struct packed
	{
		logic [7:0] tblOffset;
		logic rsvd23;
		logic [6:0] maxTimeSlots;
		logic rejectSnoop;
		logic advPacketSwitching;
		logic [5:0] rsvd13to8;
		logic [7:0] portArbCapability;
	} capWord_t;

	typedef enum logic [2:0]
	{
		SEL_NONE = 3'b001,
		SEL_STATUS = 3'b010,
		SEL_CAP = 3'b100
	} regSel_t;

	// Low two address bits are ignored: each register is one aligned word
	function automatic regSel_t decodeReg(input logic [11:0] addr);
		regSel_t sel;
		sel = SEL_NONE;
		if (addr[11:2] == 10'(`VC_STATUS_ADDR >> 2))
			sel = SEL_STATUS;
		else if (addr[11:2] == 10'(`VC_CAP_ADDR >> 2))
			sel = SEL_CAP;
		return sel;
	endfunction

	function automatic logic [1:0] respFor(input regSel_t sel);
		return (sel == SEL_NONE) ? `AXIL_RESP_SLVERR : `AXIL_RESP_OKAY;
	endfunction

endpackage

/* src/vc_cap_words.sv */
`include "vc_cap_map.svh"

module vc_cap_words
(
	input wire logic isUpstream,
	output logic [31:0] statusWord,
	output vc_cap_pkg::capWord_t capWord
);

	always_comb
	begin
		statusWord = 32'h0;
		statusWord[`VC_TBL_COHERENT_BIT] = `VC_TBL_COHERENT_VAL; // R01
		capWord = '0;
		capWord.portArbCapability = isUpstream ? `VC_ARB_CAP_UP
			: `VC_ARB_CAP_DN; // R02 R03 R04
		capWord.advPacketSwitching = `VC_ADV_PKT_SW_VAL; // R05
		capWord.rejectSnoop = `VC_REJECT_SNOOP_VAL; // R06
		capWord.maxTimeSlots = `VC_MAX_TS_VAL; // R07
		capWord.tblOffset = isUpstream ? `VC_TBL_OFF_UP
			: `VC_TBL_OFF_DN; // R08 R09
	end

endmodule

/* src/vc_write_join.sv */
`include "vc_cap_map.svh"

module vc_write_join
(
	input wire logic clk,
	input wire logic srst,
	input wire logic awvalid,
	output logic awready,
	input wire vc_cap_pkg::axilAddr_t awChan,
	input wire logic wvalid,
	output logic wready,
	input wire vc_cap_pkg::axilWdata_t wChan,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp
);

	typedef enum logic [1:0]
	{
		ST_COLLECT = 2'b01,
		ST_RESP = 2'b10
	} wrState_t;

	typedef struct packed
	{
		wrState_t state;
		logic haveAddr;
		logic haveData;
		logic [11:0] addr;
		logic [1:0] resp;
	} wrRegs_t;

	wrRegs_t s_r;
	wrRegs_t s_nxt;
	logic addrNow;
	logic dataNow;
	logic [11:0] addrUse;

	assign awready = (s_r.state == ST_COLLECT) && !s_r.haveAddr;
	assign wready = (s_r.state == ST_COLLECT) && !s_r.haveData;
	assign bvalid = (s_r.state == ST_RESP);
	assign bresp = s_r.resp;
	// Write data is dropped; every field is read-only
	assign addrNow = s_r.haveAddr || (awvalid && awready);
	assign dataNow = s_r.haveData || (wvalid && wready);
	assign addrUse = s_r.haveAddr ? s_r.addr : awChan.addr;

	always_comb
	begin
		s_nxt = s_r;
		case (s_r.state)
			ST_COLLECT:
			begin
				if (awvalid && awready)
				begin
					s_nxt.haveAddr = 1'b1;
					s_nxt.addr = awChan.addr;
				end
				if (wvalid && wready)
					s_nxt.haveData = 1'b1;
				if (addrNow && dataNow)
				begin
					s_nxt.state = ST_RESP;
					s_nxt.resp = vc_cap_pkg::respFor(
						vc_cap_pkg::decodeReg(addrUse)); // R11
				end
			end
			ST_RESP:
			begin
				if (bready)
				begin
					s_nxt.state = ST_COLLECT;
					s_nxt.haveAddr = 1'b0;
					s_nxt.haveData = 1'b0;
				end
			end
			default:
				s_nxt.state = ST_COLLECT;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_r.state <= ST_COLLECT;
			s_r.haveAddr <= 1'b0;
			s_r.haveData <= 1'b0;
			s_r.addr <= 12'h0;
			s_r.resp <= `AXIL_RESP_OKAY;
		end
		else
			s_r <= s_nxt;
	end

endmodule

/* src/vc_resource_capability_regs.sv */
// Function
// R01 - Table coherency status bit always reads zero
// R02 - Arbitration schemes one per bit, 7:0
// R03 - Upstream port advertises capability 0x3
// R04 - Downstream ports advertise capability 0x1
// R05 - Advanced packet switching bit reads zero
// R06 - Reject snoop bit reads zero
// R07 - Max time slots field reads zero
// R08 - Table offset in 16-byte units, 31:24
// R09 - Table offset 0x2 upstream, 0x0 downstream
// R10 - Software selects only advertised arbitration schemes
// R11 - Writes are ignored, reads never change
`include "vc_cap_map.svh"

module vc_resource_capability_regs
(
	input wire logic clk,
	input wire logic srst,
	input wire logic upstreamStrap,
	input wire logic awvalid,
	output logic awready,
	input wire vc_cap_pkg::axilAddr_t awChan,
	input wire logic wvalid,
	output logic wready,
	input wire vc_cap_pkg::axilWdata_t wChan,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire vc_cap_pkg::axilAddr_t arChan,
	output logic rvalid,
	input wire logic rready,
	output vc_cap_pkg::axilRdata_t rChan,
	output logic portIsUpstream
);

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_DATA = 2'b10
	} rdState_t;

	typedef struct packed
	{
		rdState_t state;
		logic isUpstream;
		vc_cap_pkg::axilRdata_t rd;
	} rdRegs_t;

	rdRegs_t s_r;
	rdRegs_t s_nxt;
	logic [31:0] statusWord;
	vc_cap_pkg::capWord_t capWord;
	vc_cap_pkg::regSel_t rdSel;

	vc_cap_words words
	(
		.isUpstream(s_r.isUpstream),
		.statusWord(statusWord),
		.capWord(capWord)
	);

	// Writes get a response but never reach any stored value
	vc_write_join writes
	(
		.clk(clk),
		.srst(srst),
		.awvalid(awvalid),
		.awready(awready),
		.awChan(awChan),
		.wvalid(wvalid),
		.wready(wready),
		.wChan(wChan),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp)
	); // R11

	assign arready = (s_r.state == ST_IDLE);
	assign rvalid = (s_r.state == ST_DATA);
	assign rChan = s_r.rd;
	assign portIsUpstream = s_r.isUpstream;
	assign rdSel = vc_cap_pkg::decodeReg(arChan.addr);

	always_comb
	begin
		s_nxt = s_r;
		case (s_r.state)
			ST_IDLE:
			begin
				if (arvalid)
				begin
					s_nxt.state = ST_DATA;
					s_nxt.rd.resp = vc_cap_pkg::respFor(rdSel);
					case (rdSel)
						vc_cap_pkg::SEL_STATUS:
							s_nxt.rd.data = statusWord; // R01
						vc_cap_pkg::SEL_CAP:
							s_nxt.rd.data = capWord; // R02 R08
						default:
							s_nxt.rd.data = 32'h0;
					endcase
				end
			end
			ST_DATA:
			begin
				// Data held stable until the master takes it
				if (rready)
					s_nxt.state = ST_IDLE;
			end
			default:
				s_nxt.state = ST_IDLE;
		endcase
	end

	// Strap sampled while reset is held, so the port role cannot shift later
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_r.state <= ST_IDLE;
			s_r.isUpstream <= upstreamStrap; // R03 R04 R09
			s_r.rd <= '0;
		end
		else
			s_r <= s_nxt;
	end

endmodule

/* tb/vc_resource_capability_regs_sva.sv */
module vc_cap_checker
(
	input wire logic clk,
	input wire logic srst,
	input wire logic portIsUpstream,
	input wire logic arvalid,
	input wire logic arready,
	input wire vc_cap_pkg::axilAddr_t arChan,
	input wire logic rvalid,
	input wire vc_cap_pkg::axilRdata_t rChan
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	logic capHit;
	logic stHit;
	assign capHit = arvalid && arready && arChan.addr == 12'h840;
	assign stHit = arvalid && arready && arChan.addr == 12'h838;
	a_status_zero: assert property (stHit |=> rChan.data == 32'h0)
		else $error("status word not zero");
	a_arb_up: assert property (capHit && portIsUpstream |=>
		rChan.data[7:0] == 8'h03) else $error("upstream arb field");
	a_arb_dn: assert property (capHit && !portIsUpstream |=>
		rChan.data[7:0] == 8'h01) else $error("downstream arb field");
	a_aps_zero: assert property (capHit |=> !rChan.data[14])
		else $error("packet switching bit set");
	a_snoop_zero: assert property (capHit |=> !rChan.data[15])
		else $error("snoop bit set");
	a_slots_zero: assert property (capHit |=> rChan.data[22:16] == 7'h0)
		else $error("time slots not zero");
	a_table_offset: assert property (capHit |=> rChan.data[31:24] ==
		(portIsUpstream ? 8'h02 : 8'h00)) else $error("table offset wrong");
	a_cap_answer: assert property (capHit |=> rvalid && rChan.resp == 2'h0)
		else $error("capability read not answered");
endmodule

bind vc_resource_capability_regs vc_cap_checker chk (.clk(clk), .srst(srst),
	.portIsUpstream(portIsUpstream), .arvalid(arvalid), .arready(arready),
	.arChan(arChan), .rvalid(rvalid), .rChan(rChan));

/* tb/test_vc_resource_capability_regs.sv */
module test_vc_resource_capability_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, upstreamStrap, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready, portIsUpstream;
	logic [1:0] bresp;
	vc_cap_pkg::axilAddr_t awChan, arChan;
	vc_cap_pkg::axilWdata_t wChan;
	vc_cap_pkg::axilRdata_t rChan;
	int err_count, checks;
	vc_resource_capability_regs uut
	(
		.clk(clk),
		.srst(srst),
		.upstreamStrap(upstreamStrap),
		.awvalid(awvalid),
		.awready(awready),
		.awChan(awChan),
		.wvalid(wvalid),
		.wready(wready),
		.wChan(wChan),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.arChan(arChan),
		.rvalid(rvalid),
		.rready(rready),
		.rChan(rChan),
		.portIsUpstream(portIsUpstream)
	);
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [33:0] g, input logic [33:0] e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rst(input logic up);
		@(posedge clk);
		srst <= 1;
		upstreamStrap <= up;
		repeat (16) @(posedge clk);
		srst <= 0;
		@(negedge clk);
		chk({29'h0, awready, wready, arready, bvalid, rvalid},
			{29'h0, 5'h1c});
		chk(rChan, 34'h0);
		chk({33'h0, portIsUpstream}, {33'h0, up});
	endtask
	task rd(input logic [11:0] a, input logic [33:0] e);
		@(posedge clk);
		arvalid <= 1;
		arChan <= '{a, 3'h0};
		rready <= 1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 0;
		do @(negedge clk); while (!rvalid);
		chk(rChan, e);
		@(posedge clk);
		rready <= 0;
	endtask
	// Both channels offered at once; each is dropped at its own handshake
	task wr(input logic [11:0] a, input logic [1:0] e);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		awvalid <= 1;
		wvalid <= 1;
		awChan <= '{a, 3'h0};
		wChan <= '{32'hffffffff, 4'hf};
		bready <= 1;
		do
		begin
			@(negedge clk);
			ta |= awvalid && awready;
			tw |= wvalid && wready;
			@(posedge clk);
			if (ta)
				awvalid <= 0;
			if (tw)
				wvalid <= 0;
		end while (!(ta && tw));
		do @(negedge clk); while (!bvalid);
		chk({32'h0, bresp}, {32'h0, e});
		@(posedge clk);
		bready <= 0;
	endtask
	task t_up;
		rst(1);
		rd(12'h838, 34'h0);
		rd(12'h840, {32'h02000003, 2'h0});
		rd(12'h844, {32'h0, 2'h2});
		$display("upstream reads done");
	endtask
	// Writes of all ones, then reads prove nothing moved
	task t_wr;
		wr(12'h840, 2'h0);
		wr(12'h838, 2'h0);
		wr(12'h844, 2'h2);
		rd(12'h840, {32'h02000003, 2'h0});
		rd(12'h838, 34'h0);
		$display("write tests done");
	endtask
	task t_dn;
		rst(0);
		rd(12'h840, {32'h00000001, 2'h0});
		rd(12'h838, 34'h0);
		$display("downstream reads done");
	endtask
	initial
	begin
		#20000;
		err_count++;
		close_out;
	end
	initial
	begin
		srst = 1;
		upstreamStrap = 1;
		awvalid = 0;
		wvalid = 0;
		bready = 0;
		arvalid = 0;
		rready = 0;
		awChan = '0;
		arChan = '0;
		wChan = '0;
		err_count = 0;
		checks = 0;
		t_up;
		t_wr;
		t_dn;
		close_out;
	end
endmodule
